/* hdl/mpt_consts.svh */
/*
  Offsets, field positions and reset values for the microcontroller
  parallel port takeover block.
  Assumes inclusion by bare name from files under hdl/.
*/
`ifndef MPT_CONSTS_SVH
`define MPT_CONSTS_SVH

`define MPT_ADDR_W          16
`define MPT_OFF_STATUS      16'h7F3A
`define MPT_OFF_CONTROL     16'h7F3B
`define MPT_OFF_DATA        16'h7F3C
`define MPT_RESET_VAL       8'h00
`define MPT_UNMAPPED_VAL    8'h00

`define MPT_ST_OWNER_BIT    0
`define MPT_ST_FAULT_BIT    3
`define MPT_ST_SELECT_BIT   4
`define MPT_ST_PAPER_BIT    5
`define MPT_ST_ACK_BIT      6
`define MPT_ST_BUSY_BIT     7

`define MPT_CT_STROBE_BIT   0
`define MPT_CT_ALF_BIT      1
`define MPT_CT_INIT_BIT     2
`define MPT_CT_SELIN_BIT    3
`define MPT_CT_DIR_BIT      5

`endif

/* hdl/mpt_pkg.sv */
/*
  Types shared by the parallel port takeover block.
  Assumes mpt_consts.svh supplies the numeric constants.
*/
package mpt_pkg;

  // Printer status inputs as seen at the pins
  typedef struct packed {
    logic busy;
    logic ack_low;
    logic paper_end;
    logic selected;
    logic fault_low;
  } mpt_status_pins_t;

  // Printer control outputs as driven at the pins
  typedef struct packed {
    logic strobe_low;
    logic auto_linefeed_low;
    logic initialize_low;
    logic select_request_low;
  } mpt_control_pins_t;

  // Microcontroller memory-mapped access
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mpt_bus_req_t;

  typedef enum logic [1:0] {
    MPT_SEL_NONE,
    MPT_SEL_STATUS,
    MPT_SEL_CONTROL,
    MPT_SEL_DATA
  } mpt_reg_sel_t;

endpackage

/* hdl/mpt_sync.sv */
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes pins are asynchronous to sys_clk.
*/
`timescale 1ns/1ps
module mpt_sync
  import mpt_pkg::*;
#(
  parameter int WIDTH = 13
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  if (WIDTH < 1) begin : g_width_check
    $error("mpt_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule // mpt_sync

/* hdl/mpt_pin_mux.sv */
/*
  Pin multiplexer choosing between the host/floppy controller path and
  the microcontroller registers.
  Assumes both sources run on sys_clk; outputs are flopped.
*/
`include "mpt_consts.svh"
`timescale 1ns/1ps
module mpt_pin_mux
  import mpt_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              port_owner_select,
  input  wire logic [7:0]        control_reg,
  input  wire logic [7:0]        data_reg,
  input  wire mpt_control_pins_t host_control,
  input  wire logic [7:0]        host_data_out,
  input  wire logic              host_data_oe_n,
  output mpt_control_pins_t      pin_control,
  output logic [7:0]             pin_data_out,
  output logic [7:0]             pin_data_oe_n
);

  mpt_control_pins_t mcu_control;
  logic              mcu_oe_n;

  always_comb begin
    mcu_control.strobe_low         = ~control_reg[`MPT_CT_STROBE_BIT];
    mcu_control.auto_linefeed_low  = ~control_reg[`MPT_CT_ALF_BIT];
    mcu_control.select_request_low = ~control_reg[`MPT_CT_SELIN_BIT];
    mcu_control.initialize_low     = control_reg[`MPT_CT_INIT_BIT];
    mcu_oe_n                       = control_reg[`MPT_CT_DIR_BIT];
  end

  // Host owns when the owner bit is set; registers then have no effect
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_control   <= '0;
      pin_data_out  <= '0;
      pin_data_oe_n <= '1;
    end else if (port_owner_select) begin
      pin_control   <= host_control;
      pin_data_out  <= host_data_out;
      pin_data_oe_n <= {8{host_data_oe_n}};
    end else begin
      pin_control   <= mcu_control;
      pin_data_out  <= data_reg;
      pin_data_oe_n <= {8{mcu_oe_n}};
    end
  end

endmodule // mpt_pin_mux

/* hdl/mpt_takeover.sv */
/*
  Microcontroller takeover of the parallel printer port: status, control
  and data registers on the microcontroller memory bus, plus the pin mux.
  Assumes a single-cycle rd/wr strobe bus on sys_clk; read data is
  registered and valid the cycle after rd. Pins are asynchronous.
*/
`include "mpt_consts.svh"
`timescale 1ns/1ps
// Function
// - Status register: only bit 0 writable, rest read-only, no host access.
// - Owner bit 1 gives pins to host path; 0 (reset) to microcontroller.
// - Status bit 7 reads inverse of the busy pin while owned.
// - Status bits 6..3 read ack, paper-end, select, fault pins uninverted.
// - Strobe, linefeed, select-in pins driven inverted from control bits 0,1,3.
// - Initialize pin driven uninverted from control bit 2.
// - Control bit 5 low drives data pins; high floats them for input.
// - Data register read returns live data pin levels while owned.
// - Three consecutive registers, all reset to zero.
module mpt_takeover
  import mpt_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire mpt_bus_req_t      bus_req,
  output logic [7:0]             bus_rdata,
  output logic                   bus_rvalid,
  input  wire mpt_status_pins_t  pin_status,
  input  wire logic [7:0]        pin_data_in,
  output mpt_control_pins_t      pin_control,
  output logic [7:0]             pin_data_out,
  output logic [7:0]             pin_data_oe_n,
  input  wire mpt_control_pins_t host_control,
  input  wire logic [7:0]        host_data_out,
  input  wire logic              host_data_oe_n,
  output mpt_status_pins_t       host_status,
  output logic [7:0]             host_data_in,
  output logic                   port_owner_select
);

  localparam int SYNC_W = 13;

  // Refuse a register map, reset value, synchroniser width or field layout the logic cannot serve
  if (`MPT_OFF_CONTROL != `MPT_OFF_STATUS + 16'h0001 ||
      `MPT_OFF_DATA != `MPT_OFF_CONTROL + 16'h0001) begin : g_map_check
    $error("mpt_takeover: registers must sit at consecutive addresses");
  end
  if (`MPT_RESET_VAL != 8'h00) begin : g_reset_check
    $error("mpt_takeover: registers must reset to zero");
  end
  if (SYNC_W != $bits(mpt_status_pins_t) + 8) begin : g_sync_check
    $error("mpt_takeover: synchroniser must cover the status and data pins");
  end
  if (`MPT_ST_BUSY_BIT > 7 || `MPT_CT_DIR_BIT > 7) begin : g_field_check
    $error("mpt_takeover: field positions must lie inside a byte");
  end

  logic              owner_reg;
  logic [7:0]        control_reg;
  logic [7:0]        data_reg;
  logic [SYNC_W-1:0] sync_bus;
  mpt_status_pins_t  status_sync;
  logic [7:0]        data_sync;
  mpt_reg_sel_t      reg_sel;
  logic [7:0]        status_view;
  logic [7:0]        rdata_next;

  mpt_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .async_in ({pin_status, pin_data_in}),
    .sync_out (sync_bus)
  );

  assign status_sync       = sync_bus[12:8];
  assign data_sync         = sync_bus[7:0];
  assign port_owner_select = owner_reg;
  assign host_status       = status_sync;
  assign host_data_in      = data_sync;

  always_comb begin
    unique case (bus_req.addr)
      `MPT_OFF_STATUS:  reg_sel = MPT_SEL_STATUS;
      `MPT_OFF_CONTROL: reg_sel = MPT_SEL_CONTROL;
      `MPT_OFF_DATA:    reg_sel = MPT_SEL_DATA;
      default:          reg_sel = MPT_SEL_NONE;
    endcase
  end

  // Owner bit: the only writable status bit
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      owner_reg <= 1'b0;
    end else if (bus_req.wr && reg_sel == MPT_SEL_STATUS) begin
      owner_reg <= bus_req.wdata[`MPT_ST_OWNER_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      control_reg <= `MPT_RESET_VAL;
    end else if (bus_req.wr && reg_sel == MPT_SEL_CONTROL) begin
      control_reg <= bus_req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      data_reg <= `MPT_RESET_VAL;
    end else if (bus_req.wr && reg_sel == MPT_SEL_DATA) begin
      data_reg <= bus_req.wdata;
    end
  end

  // Live pin levels only while the microcontroller owns the port
  always_comb begin
    status_view = 8'h00;
    status_view[`MPT_ST_OWNER_BIT] = owner_reg;
    if (!owner_reg) begin
      status_view[`MPT_ST_BUSY_BIT]   = ~status_sync.busy;
      status_view[`MPT_ST_ACK_BIT]    = status_sync.ack_low;
      status_view[`MPT_ST_PAPER_BIT]  = status_sync.paper_end;
      status_view[`MPT_ST_SELECT_BIT] = status_sync.selected;
      status_view[`MPT_ST_FAULT_BIT]  = status_sync.fault_low;
    end
  end

  always_comb begin
    unique case (reg_sel)
      MPT_SEL_STATUS:  rdata_next = status_view;
      MPT_SEL_CONTROL: rdata_next = control_reg;
      MPT_SEL_DATA:    rdata_next = owner_reg ? data_reg : data_sync;
      MPT_SEL_NONE:    rdata_next = `MPT_UNMAPPED_VAL;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bus_rdata  <= 8'h00;
      bus_rvalid <= 1'b0;
    end else begin
      bus_rvalid <= bus_req.rd;
      if (bus_req.rd) begin
        bus_rdata <= rdata_next;
      end
    end
  end

  mpt_pin_mux u_mux (
    .sys_clk           (sys_clk),
    .sys_rst           (sys_rst),
    .port_owner_select (owner_reg),
    .control_reg       (control_reg),
    .data_reg          (data_reg),
    .host_control      (host_control),
    .host_data_out     (host_data_out),
    .host_data_oe_n    (host_data_oe_n),
    .pin_control       (pin_control),
    .pin_data_out      (pin_data_out),
    .pin_data_oe_n     (pin_data_oe_n)
  );

endmodule // mpt_takeover

/* tb/mpt_takeover_checker.sv */
/* Port assertions for the parallel port takeover block.
   Assumes it is bound to mpt_takeover on sys_clk. */
`include "mpt_consts.svh"
`timescale 1ns/1ps
module mpt_takeover_checker
  import mpt_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              sys_rst,
  input wire mpt_bus_req_t      bus_req,
  input wire logic [7:0]        bus_rdata,
  input wire logic              bus_rvalid,
  input wire mpt_status_pins_t  pin_status,
  input wire logic [7:0]        pin_data_in,
  input wire mpt_control_pins_t pin_control,
  input wire logic [7:0]        pin_data_out,
  input wire logic [7:0]        pin_data_oe_n,
  input wire mpt_control_pins_t host_control,
  input wire logic [7:0]        host_data_out,
  input wire logic              port_owner_select
);
  logic [7:0] wd1_reg;
  logic [7:0] wd2_reg;
  // Write data two edges back, aligned with the pin update
  always_ff @(posedge sys_clk) begin
    wd1_reg <= bus_req.wdata;
    wd2_reg <= wd1_reg;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence wctl;
    bus_req.wr && bus_req.addr == `MPT_OFF_CONTROL ##1 !port_owner_select;
  endsequence
  sequence wdat;
    bus_req.wr && bus_req.addr == `MPT_OFF_DATA ##1 !port_owner_select;
  endsequence
  rvalid_follows_a: assert property (
    bus_req.rd |=> bus_rvalid) else $error("read not answered");
  ctrl_inverted_a: assert property (
    wctl |=> {pin_control[3:2], pin_control[0]} == ~{wd2_reg[0], wd2_reg[1], wd2_reg[3]})
    else $error("inverted control pins wrong");
  init_direct_a: assert property (
    wctl |=> pin_control.initialize_low == wd2_reg[2]) else $error("init pin wrong");
  data_dir_a: assert property (
    wctl |=> pin_data_oe_n == {8{wd2_reg[5]}}) else $error("data direction wrong");
  data_drive_a: assert property (
    wdat |=> pin_data_oe_n[0] || pin_data_out == wd2_reg) else $error("data pins wrong");
  host_owns_a: assert property (
    $past(port_owner_select) |-> pin_control == $past(host_control)
      && pin_data_out == $past(host_data_out)) else $error("host path not passed");
  status_read_a: assert property (
    $stable(pin_status)[*4] ##0 bus_req.rd && bus_req.addr == `MPT_OFF_STATUS
      && !port_owner_select
      |=> bus_rdata == {~$past(pin_status[4]), $past(pin_status[3:0]), 3'b000})
    else $error("status read wrong");
  data_read_a: assert property (
    $stable(pin_data_in)[*4] ##0 bus_req.rd && bus_req.addr == `MPT_OFF_DATA
      && !port_owner_select |=> bus_rdata == $past(pin_data_in)) else $error("data read wrong");
  cover property (wctl);
  cover property (port_owner_select);
  cover property (bus_req.rd && pin_data_oe_n[0]);
endmodule // mpt_takeover_checker

bind mpt_takeover mpt_takeover_checker mpt_takeover_checker_i (.sys_clk, .sys_rst, .bus_req,
  .bus_rdata, .bus_rvalid, .pin_status, .pin_data_in, .pin_control, .pin_data_out,
  .pin_data_oe_n, .host_control, .host_data_out, .port_owner_select);

/* tb/mpt_periph_model.sv */
/* Peripheral on the printer pins: status levels and data lines.
   Assumes the bench sets status levels and the data it returns. */
`timescale 1ns/1ps
module mpt_periph_model
  import mpt_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic [7:0]       pin_data_out,
  input  wire logic [7:0]       pin_data_oe_n,
  input  wire logic             drive_en,
  input  wire logic [7:0]       drive_val,
  input  wire mpt_status_pins_t status_val,
  output mpt_status_pins_t      pin_status,
  output logic [7:0]            pin_data_in
);
  logic [7:0] idle_reg = 8'h55;
  // Undriven lines toggle so a stale value is never read back
  always @(posedge sys_clk) idle_reg <= ~idle_reg;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_data_in[i] = !pin_data_oe_n[i] ? pin_data_out[i]
                     : drive_en ? drive_val[i] : idle_reg[i];
    end
  end
  assign pin_status = status_val;
endmodule // mpt_periph_model

/* tb/tb_mpt_takeover.sv */
/* Bench for the parallel port takeover block.
   Assumes the peripheral model and the bound checker. */
`include "mpt_consts.svh"
`timescale 1ns/1ps
module tb_mpt_takeover
  import mpt_pkg::*;
;
  logic              sys_clk, sys_rst, drive_en, host_data_oe_n, bus_rvalid, port_owner_select;
  logic [7:0]        bus_rdata, pin_data_out, pin_data_oe_n, host_data_out, drive_val;
  logic [7:0]        pin_data_in, host_data_in, c;
  mpt_bus_req_t      bus_req;
  mpt_status_pins_t  pin_status, status_val, host_status;
  mpt_control_pins_t pin_control, host_control;
  int                num_errors, compares, cycles;
  mpt_takeover mpt_takeover_i (.sys_clk, .sys_rst, .bus_req, .bus_rdata, .bus_rvalid, .pin_status,
    .pin_data_in, .pin_control, .pin_data_out, .pin_data_oe_n, .host_control, .host_data_out,
    .host_data_oe_n, .host_status, .host_data_in, .port_owner_select);
  mpt_periph_model mpt_periph_model_i (.sys_clk, .pin_data_out, .pin_data_oe_n, .drive_en,
    .drive_val, .status_val, .pin_status, .pin_data_in);
  task automatic report_and_stop();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    bus_req.wr = 1'b1;
    bus_req.addr = a;
    bus_req.wdata = d;
    @(negedge sys_clk);
    bus_req.wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    bus_req.rd = 1'b1;
    bus_req.addr = a;
    @(negedge sys_clk);
    bus_req.rd = 1'b0;
    chk({7'h00, bus_rvalid}, 8'h01);
    chk(bus_rdata, exp);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    sys_rst = 1'b1;
    bus_req = '0;
    host_control = 4'h0;
    host_data_out = 8'h00;
    host_data_oe_n = 1'b1;
    drive_en = 1'b0;
    drive_val = 8'h00;
    status_val = 5'h10;
    idle(12);
    sys_rst = 1'b0;
    idle(4);
    rd(`MPT_OFF_STATUS, 8'h00);
    rd(`MPT_OFF_CONTROL, 8'h00);
    rd(`MPT_OFF_DATA, 8'h00);
    for (int i = 0; i < 5; i++) begin
      status_val = 5'(1 << i);
      idle(4);
      rd(`MPT_OFF_STATUS, {~status_val[4], status_val[3:0], 3'b000});
      chk({3'h0, host_status}, {3'h0, status_val});
    end
    status_val = 5'h00;
    wr(`MPT_OFF_STATUS, 8'hFE);
    idle(4);
    rd(`MPT_OFF_STATUS, 8'h80);
    for (int b = 0; b < 4; b++) begin
      c = 8'(1 << b);
      wr(`MPT_OFF_CONTROL, c);
      idle(2);
      chk({4'h0, pin_control}, {4'h0, ~c[0], ~c[1], c[2], ~c[3]});
      rd(`MPT_OFF_CONTROL, c);
    end
    wr(`MPT_OFF_CONTROL, 8'h00);
    wr(`MPT_OFF_DATA, 8'h5A);
    idle(2);
    chk(pin_data_out, 8'h5A);
    chk(pin_data_oe_n, 8'h00);
    idle(2);
    rd(`MPT_OFF_DATA, 8'h5A);
    drive_en = 1'b1;
    drive_val = 8'hC3;
    wr(`MPT_OFF_CONTROL, 8'h20);
    idle(2);
    chk(pin_data_oe_n, 8'hFF);
    idle(3);
    rd(`MPT_OFF_DATA, 8'hC3);
    chk(host_data_in, 8'hC3);
    drive_en = 1'b0;
    wr(16'h7F3D, 8'h77);
    rd(16'h7F3D, 8'h00);
    host_control = 4'h5;
    host_data_out = 8'h99;
    host_data_oe_n = 1'b0;
    wr(`MPT_OFF_STATUS, 8'h01);
    wr(`MPT_OFF_CONTROL, 8'h0F);
    idle(2);
    chk({4'h0, pin_control}, 8'h05);
    chk(pin_data_out, 8'h99);
    rd(`MPT_OFF_STATUS, 8'h01);
    wr(`MPT_OFF_STATUS, 8'h00);
    idle(2);
    chk({4'h0, pin_control}, 8'h02);
    report_and_stop();
  end
endmodule // tb_mpt_takeover
